// [design/wepc_top.sv]
`timescale 1ns/1ps
module wepc_top
    import wepc_pkg::*;
#(
    parameter int P_WAKE_UNIT_CYC = WAKE_UNIT_CYC,
    parameter int P_SLEEP_UNIT_CYC = SLEEP_UNIT_CYC
)(
    input wire logic i_clk_sys,                // system clock
    input wire logic i_srst,                   // power-up reset
    input wire logic i_hwsw_rst,               // hardware or software reset
    input wire wepc_evt_t i_evt,               // wake event pulses
    input wire logic i_energy,                 // line energy present level
    input wire logic i_clocks_ready,           // all clocks run, host ok
    input wire logic [AXI_AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid,            // write address valid
    output logic s_axi_awready,                // write address ready
    input wire logic [31:0] s_axi_wdata,       // write data
    input wire logic [3:0] s_axi_wstrb,        // write strobes
    input wire logic s_axi_wvalid,             // write data valid
    output logic s_axi_wready,                 // write data ready
    output logic [1:0] s_axi_bresp,            // write response
    output logic s_axi_bvalid,                 // write response valid
    input wire logic s_axi_bready,             // write response ready
    input wire logic [AXI_AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid,            // read address valid
    output logic s_axi_arready,                // read address ready
    output logic [31:0] s_axi_rdata,           // read data
    output logic [1:0] s_axi_rresp,            // read response
    output logic s_axi_rvalid,                 // read data valid
    input wire logic s_axi_rready,             // read data ready
    output logic o_wake_event_output,          // wake pin level
    output logic o_irq,                        // level interrupt
    output logic o_low_power,                  // low-power state
    output logic o_rxtx_en                     // packets may flow
);
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] pec;
        logic [3:0] cause;
        logic [15:0] swt;
        logic [1:0] isw;
        logic [1:0] imsk;
        wepc_pwr_t pwr;
        logic [7:0] wake_cnt;
        logic [7:0] sleep_cnt;
        logic wake_out;
        logic irq;
        logic rxtx_en;
    } wepc_state_t;

    wepc_state_t st_reg;
    wepc_state_t st_next;
    logic wake_tick;
    logic sleep_tick;
    logic wake_clr;
    logic sleep_clr;

    // divider restarts whenever the continuous condition breaks
    assign wake_clr = ~i_energy | (st_reg.pwr != PWR_LOW);
    assign sleep_clr = i_energy | (st_reg.pwr != PWR_ACTIVE)
        | (st_reg.pec[PEC_MODE_LSB +: 2] != MODE_ENERGY);

    // 16 ms unit for the wake-up time
    wepc_tick #(
        .P_PERIOD(P_WAKE_UNIT_CYC)
    ) u_wake_tick (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_clear(wake_clr),
        .o_tick(wake_tick)
    );

    // one-second unit for the go-sleep time
    wepc_tick #(
        .P_PERIOD(P_SLEEP_UNIT_CYC)
    ) u_sleep_tick (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_clear(sleep_clr),
        .o_tick(sleep_tick)
    );

    // next state of bus slave, registers and power control
    always_comb
    begin
        logic aw_hs;
        logic w_hs;
        logic ar_hs;
        logic do_wr;
        logic [7:0] wa;
        logic [7:0] ra;
        logic [3:0] clr;
        logic [3:0] set;
        logic [1:0] isw_clr;
        logic [1:0] isw_set;
        logic [7:0] wake_n;
        logic [7:0] sleep_n;
        logic wake_met;
        logic sleep_met;
        logic pending;
        logic hold;
        logic active;
        aw_hs = s_axi_awvalid & st_reg.awready;
        w_hs = s_axi_wvalid & st_reg.wready;
        ar_hs = s_axi_arvalid & st_reg.arready;
        do_wr = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
        wa = {st_reg.aw_addr[7:2], 2'b00};
        ra = {s_axi_araddr[7:2], 2'b00};
        clr = 4'h0;
        set = 4'h0;
        isw_clr = 2'h0;
        isw_set = 2'h0;
        st_next = st_reg;

        // capture address and data in either order
        if (aw_hs)
        begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (w_hs)
        begin
            st_next.w_got = 1'b1;
            st_next.w_data = s_axi_wdata[15:0];
            st_next.w_strb = s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            st_next.bvalid = 1'b0;
        end

        // register write once both halves are in
        if (do_wr)
        begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            case (wa)
                ADDR_PEC:
                begin
                    if (st_reg.w_strb[0])
                    begin
                        st_next.pec[7:0] = st_reg.w_data[7:0] & PEC_WMASK[7:0];
                        clr = st_reg.w_data[PEC_CAUSE_LSB +: 4];
                    end
                    if (st_reg.w_strb[1])
                    begin
                        st_next.pec[15:8] = st_reg.w_data[15:8]
                            & PEC_WMASK[15:8];
                    end
                end
                ADDR_SWT:
                begin
                    if (st_reg.w_strb[0])
                    begin
                        st_next.swt[7:0] = st_reg.w_data[7:0];
                    end
                    if (st_reg.w_strb[1])
                    begin
                        st_next.swt[15:8] = st_reg.w_data[15:8];
                    end
                end
                ADDR_ISW:
                begin
                    if (st_reg.w_strb[0])
                    begin
                        isw_clr = {st_reg.w_data[ISW_LINK_BIT],
                            st_reg.w_data[ISW_ENERGY_BIT]};
                    end
                end
                ADDR_IMSK:
                begin
                    if (st_reg.w_strb[0])
                    begin
                        st_next.imsk = {st_reg.w_data[ISW_LINK_BIT],
                            st_reg.w_data[ISW_ENERGY_BIT]};
                    end
                end
                default:
                begin
                    st_next.bresp = RESP_SLVERR;
                end
            endcase
        end

        // register read, answered one cycle after the address
        if (s_axi_rvalid && s_axi_rready)
        begin
            st_next.rvalid = 1'b0;
        end
        if (ar_hs)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            case (ra)
                ADDR_PEC:
                begin
                    st_next.rdata[15:0] = (st_reg.pec & PEC_WMASK)
                        | {10'h000, st_reg.cause, 2'h0};
                end
                ADDR_SWT:
                begin
                    st_next.rdata[15:0] = st_reg.swt;
                end
                ADDR_ISW:
                begin
                    st_next.rdata[ISW_LINK_BIT] = st_reg.isw[1];
                    st_next.rdata[ISW_ENERGY_BIT] = st_reg.isw[0];
                end
                ADDR_IMSK:
                begin
                    st_next.rdata[ISW_LINK_BIT] = st_reg.imsk[1];
                    st_next.rdata[ISW_ENERGY_BIT] = st_reg.imsk[0];
                end
                default:
                begin
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end

        // continuous energy and no-energy unit counters
        wake_n = st_reg.wake_cnt;
        if (wake_clr)
        begin
            wake_n = 8'h00;
        end
        else if (wake_tick && (wake_n != 8'hff))
        begin
            wake_n = wake_n + 8'h01;
        end
        sleep_n = st_reg.sleep_cnt;
        if (sleep_clr)
        begin
            sleep_n = 8'h00;
        end
        else if (sleep_tick && (sleep_n != 8'hff))
        begin
            sleep_n = sleep_n + 8'h01;
        end
        st_next.wake_cnt = wake_n;
        st_next.sleep_cnt = sleep_n;
        wake_met = (st_reg.wake_cnt != 8'h00)
            && (st_reg.wake_cnt >= st_reg.swt[SWT_WAKE_LSB +: 8]);
        sleep_met = (st_reg.sleep_cnt != 8'h00)
            && (st_reg.sleep_cnt >= st_reg.swt[SWT_SLEEP_LSB +: 8]);

        // power state of energy-detect mode
        case (st_reg.pwr)
            PWR_LOW:
            begin
                if (st_reg.pec[PEC_MODE_LSB +: 2] != MODE_ENERGY)
                begin
                    st_next.pwr = PWR_ACTIVE;
                end
                else if (st_reg.pec[PEC_AUTO_BIT] && wake_met)
                begin
                    st_next.pwr = PWR_ACTIVE;
                    set = set | CAUSE_ENERGY;
                    if (st_reg.pec[PEC_NORM_BIT])
                    begin
                        st_next.pec[PEC_MODE_LSB +: 2] = MODE_NORMAL;
                    end
                end
                else if (aw_hs || ar_hs)
                begin
                    st_next.pwr = PWR_ACTIVE;
                end
            end
            PWR_ACTIVE:
            begin
                if ((st_reg.pec[PEC_MODE_LSB +: 2] == MODE_ENERGY)
                    && sleep_met)
                begin
                    st_next.pwr = PWR_LOW;
                end
            end
            default:
            begin
                st_next.pwr = PWR_ACTIVE;
            end
        endcase

        // wake causes, a new event wins over a clear in the same cycle
        set = set | i_evt;
        isw_set = {set[1], set[0]};
        st_next.cause = (st_reg.cause & ~clr) | set;
        st_next.isw = (st_reg.isw & ~isw_clr) | isw_set;

        // hardware or software reset spares the wake cause bits
        if (i_hwsw_rst)
        begin
            st_next.pec = PEC_RST;
            st_next.swt = SWT_RST;
            st_next.isw = ISW_RST;
            st_next.imsk = IMSK_RST;
            st_next.pwr = PWR_ACTIVE;
        end

        // wake pin from enabled pending causes, polarity and delay
        pending = |(st_reg.cause & st_reg.pec[PEC_EN_LSB +: 4]);
        hold = st_reg.pec[PEC_DLY_BIT] & st_reg.pec[PEC_AUTO_BIT]
            & ~i_clocks_ready;
        active = pending & ~hold;
        st_next.wake_out = st_reg.pec[PEC_POL_BIT] ? active : ~active;
        st_next.irq = |(st_reg.isw & st_reg.imsk);
        st_next.rxtx_en = (st_reg.pwr == PWR_ACTIVE)
            && (st_reg.pec[PEC_MODE_LSB +: 2] != MODE_SAVE);

        // readies follow the pending transfers
        st_next.awready = ~st_next.aw_got & ~st_next.bvalid;
        st_next.wready = ~st_next.w_got & ~st_next.bvalid;
        st_next.arready = ~st_next.rvalid;
    end

    // one register for the whole state
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            st_reg <= '0;
            st_reg.pec <= PEC_RST;
            st_reg.swt <= SWT_RST;
            st_reg.isw <= ISW_RST;
            st_reg.imsk <= IMSK_RST;
            st_reg.pwr <= PWR_ACTIVE;
            st_reg.wake_out <= 1'b1; // inactive high while polarity is zero
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign o_wake_event_output = st_reg.wake_out;
    assign o_irq = st_reg.irq;
    assign o_low_power = (st_reg.pwr == PWR_LOW);
    assign o_rxtx_en = st_reg.rxtx_en;
endmodule

// [design/wepc_pkg.sv]
// Overview of operation
// - With delay enable set and auto wake-up on, the wake output waits until all clocks run and the host can access the device; with it clear there is no delay.
// - The wake output is active high when the polarity bit is one and active low when it is zero.
// - Enable bits 11, 10, 9 and 8 belong to wake-up frame, patterned wake packet, link up and energy detection.
// - An event whose enable bit is one asserts the wake output; an event whose enable bit is zero leaves it deasserted.
// - With auto wake-up set in energy-detect mode, low power is left once energy lasts past the wake-up time; with it clear it is not.
// - In the normal-power state of energy-detect mode the device can still receive and transmit.
// - With bit 6 set and auto wake-up on, an energy wake-up also switches the mode field to normal; with it clear the mode stays energy-detect.
// - The wake cause field at bits 5-2 reads 0001 energy, 0010 link up, 0100 patterned packet, 1000 wake-up frame, 0000 none.
// - Recording an energy cause also sets interrupt status bit 2, and a link-up cause sets bit 3.
// - The wake cause bits clear only on power-up reset or a host write of one, never on hardware or software reset.
// - Once the wake cause bits are cleared the wake output is deasserted.
// - The mode field reads 00 normal, 01 energy-detect, 11 power saving, 10 reserved; any host access also wakes the device from low power.
// - Leaving low power needs energy continuously for the wake-up count times 16 ms; the count defaults to eight.
// - Entering low power needs no energy continuously for the go-sleep count in seconds; the count defaults to twelve.
package wepc_pkg;
    localparam int AXI_AW = 8;
    // register byte addresses
    localparam logic [7:0] ADDR_PEC = 8'hd4;
    localparam logic [7:0] ADDR_SWT = 8'hd8;
    localparam logic [7:0] ADDR_ISW = 8'hdc;
    localparam logic [7:0] ADDR_IMSK = 8'he0;
    // power_event_control fields
    localparam int PEC_DLY_BIT = 14;
    localparam int PEC_POL_BIT = 12;
    localparam int PEC_EN_LSB = 8;
    localparam int PEC_AUTO_BIT = 7;
    localparam int PEC_NORM_BIT = 6;
    localparam int PEC_CAUSE_LSB = 2;
    localparam int PEC_MODE_LSB = 0;
    localparam logic [15:0] PEC_WMASK = 16'h5fc3;
    localparam logic [15:0] PEC_RST = 16'h0000;
    // wake cause codes, also the event order of the enable field
    localparam logic [3:0] CAUSE_ENERGY = 4'h1;
    localparam logic [3:0] CAUSE_LINK = 4'h2;
    localparam logic [3:0] CAUSE_PATTERN = 4'h4;
    localparam logic [3:0] CAUSE_FRAME = 4'h8;
    // power mode field
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_ENERGY = 2'h1;
    localparam logic [1:0] MODE_SAVE = 2'h3;
    // sleep_wake_time_setting fields and reset value
    localparam int SWT_WAKE_LSB = 8;
    localparam int SWT_SLEEP_LSB = 0;
    localparam logic [15:0] SWT_RST = 16'h080c;
    // interrupt_status_word bits
    localparam int ISW_ENERGY_BIT = 2;
    localparam int ISW_LINK_BIT = 3;
    localparam logic [1:0] ISW_RST = 2'h0;
    localparam logic [1:0] IMSK_RST = 2'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // time units
    localparam int CLK_HZ = 50_000_000;
    localparam int WAKE_UNIT_MS = 16;
    localparam int SLEEP_UNIT_S = 1;
    localparam int WAKE_UNIT_CYC = (CLK_HZ / 1000) * WAKE_UNIT_MS;
    localparam int SLEEP_UNIT_CYC = CLK_HZ * SLEEP_UNIT_S;

    // wake events, bit order matches enable and cause fields
    typedef struct packed {
        logic frame;
        logic pattern;
        logic link_up;
        logic energy;
    } wepc_evt_t;

    typedef enum logic {PWR_ACTIVE, PWR_LOW} wepc_pwr_t;
endpackage

// [design/wepc_tick.sv]
`timescale 1ns/1ps
module wepc_tick
    import wepc_pkg::*;
#(
    parameter int P_PERIOD = WAKE_UNIT_CYC
)(
    input wire logic i_clk_sys, // system clock
    input wire logic i_srst,    // synchronous reset
    input wire logic i_clear,   // restart the period
    output logic o_tick         // one-cycle pulse per period
);
    localparam int W = (P_PERIOD > 1) ? $clog2(P_PERIOD) : 1;
    localparam logic [W-1:0] LAST = W'(P_PERIOD - 1);

    logic [W-1:0] cnt_reg;
    logic tick_reg;

    // count cycles, pulse in the cycle after the last count of each period
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst || i_clear)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else if (cnt_reg == LAST)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    assign o_tick = tick_reg;
endmodule

// [verif/wepc_host_mon.sv]
`timescale 1ns/1ps
module wepc_host_mon (
    input wire logic i_pin, // wake pin level
    input wire logic i_pol, // polarity the host programmed
    output logic o_wake     // host sees a wake request
);
    // host decodes the pin with its own polarity setting
    assign o_wake = (i_pin === i_pol);
endmodule

// [verif/wepc_chk.sv]
`timescale 1ns/1ps
module wepc_chk
    import wepc_pkg::*;
(
    input wire logic i_clk_sys, // clock
    input wire logic i_srst, // power-up reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [AXI_AW-1:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic o_wake_event_output, // wake pin
    input wire logic o_irq, // interrupt
    input wire logic o_low_power, // low power
    input wire logic o_rxtx_en // traffic allowed
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    // power-up reset idles the pin and clears status
    AST_RST_PIN: assert property (disable iff (1'b0)
        i_srst |=> o_wake_event_output) else $error("pin not idle");
    AST_RST_BUS: assert property (disable iff (1'b0)
        i_srst |=> !s_axi_bvalid && !s_axi_rvalid && !o_irq)
        else $error("outputs busy after reset");
    // answers stand until the master accepts them
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    // answer latencies
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    AST_RD_MISS: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h00 |=> s_axi_rresp == RESP_SLVERR
        && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    // no traffic while asleep
    AST_LP_QUIET: assert property (o_low_power && $past(o_low_power)
        |-> !o_rxtx_en) else $error("traffic in low power");
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench
    import wepc_pkg::*;
;
    typedef struct packed {
        logic [3:0] evt;
        logic [3:0] en;
        logic pol;
        logic [3:0] cause;
        logic wake;
    } wepc_row_t;
    wepc_row_t rows [6] = '{'{4'h1, 4'h1, 1'b1, 4'h1, 1'b1},
        '{4'h2, 4'h2, 1'b1, 4'h2, 1'b1}, '{4'h4, 4'h4, 1'b1, 4'h4, 1'b1},
        '{4'h8, 4'h8, 1'b0, 4'h8, 1'b1}, '{4'h8, 4'h7, 1'b1, 4'h8, 1'b0},
        '{4'h4, 4'h0, 1'b0, 4'h4, 1'b0}};
    logic i_clk_sys = 1'b0;
    logic i_srst = 1'b1;
    logic i_hwsw_rst = 1'b0;
    logic i_energy = 1'b1;
    logic i_clocks_ready = 1'b0;
    logic pol = 1'b0;
    wepc_evt_t i_evt = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, o_wake_event_output, o_irq, o_low_power;
    logic o_rxtx_en, mon_wake;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    int errors = 0, tests_run = 0, cycles = 0;

    wepc_top #(.P_WAKE_UNIT_CYC(10), .P_SLEEP_UNIT_CYC(20)) uut (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_hwsw_rst(i_hwsw_rst),
        .i_evt(i_evt), .i_energy(i_energy), .i_clocks_ready(i_clocks_ready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .o_wake_event_output(o_wake_event_output),
        .o_irq(o_irq), .o_low_power(o_low_power), .o_rxtx_en(o_rxtx_en));
    wepc_host_mon u_host (.i_pin(o_wake_event_output), .i_pol(pol),
        .o_wake(mon_wake));

    // clock and hang guard
    always #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bus write: both channels offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge i_clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'(d);
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge i_clk_sys);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            aw_ok = aw_ok | (s_axi_awready === 1'b1);
            w_ok = w_ok | (s_axi_wready === 1'b1);
        end
        do
            @(posedge i_clk_sys);
        while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // bus read
    task automatic axi_rd(input logic [7:0] a);
        @(posedge i_clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge i_clk_sys);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge i_clk_sys);
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // one-cycle event pulse, then let the pin settle
    task automatic pulse(input logic [3:0] e);
        @(posedge i_clk_sys);
        i_evt <= e;
        @(posedge i_clk_sys);
        i_evt <= '0;
        repeat (3) @(posedge i_clk_sys);
    endtask

    task automatic wait_lp(input logic v);
        for (int n = 0; n < 200 && o_low_power !== v; n++)
            @(posedge i_clk_sys);
    endtask

    initial
    begin
        repeat (12) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        axi_rd(ADDR_PEC);
        chk(rd, 32'h0);
        axi_rd(ADDR_SWT);
        chk(rd, 32'h0000080c);
        axi_rd(8'h00);
        chk(32'(rsp), 32'(RESP_SLVERR));
        axi_wr(8'hfc, 16'hffff);
        chk(32'(rsp), 32'(RESP_SLVERR));
        axi_wr(ADDR_PEC, 16'hffc3);
        chk(32'(rsp), 32'(RESP_OKAY));
        axi_rd(ADDR_PEC);
        chk(rd, 32'h00005fc3);
        chk(32'(o_rxtx_en), 32'h0);
        // event table: enables, polarity, cause codes, clear
        for (int i = 0; i < 6; i++)
        begin
            pol <= rows[i].pol;
            axi_wr(ADDR_PEC, {3'h0, rows[i].pol, rows[i].en, 8'h00});
            pulse(rows[i].evt);
            chk(32'(mon_wake), 32'(rows[i].wake));
            axi_rd(ADDR_PEC);
            chk(32'(rd[5:2]), 32'(rows[i].cause));
            axi_wr(ADDR_PEC, {3'h0, rows[i].pol, rows[i].en, 8'h3c});
            repeat (2) @(posedge i_clk_sys);
            chk(32'(mon_wake), 32'h0);
        end
        // interrupt: raise, mask, clear
        axi_wr(ADDR_ISW, 16'h000c);
        axi_wr(ADDR_IMSK, 16'h000c);
        pulse(4'h3);
        chk(32'(o_irq), 32'h1);
        axi_rd(ADDR_ISW);
        chk(rd, 32'h0000000c);
        axi_wr(ADDR_IMSK, 16'h0004);
        axi_wr(ADDR_ISW, 16'h0004);
        repeat (2) @(posedge i_clk_sys);
        chk(32'(o_irq), 32'h0);
        axi_wr(ADDR_ISW, 16'h0008);
        axi_wr(ADDR_PEC, 16'h003c);
        // energy-detect without auto wake: only host access wakes
        axi_wr(ADDR_SWT, 16'h0201);
        i_energy <= 1'b0;
        axi_wr(ADDR_PEC, 16'h0001);
        wait_lp(1'b1);
        chk(32'(o_low_power), 32'h1);
        i_energy <= 1'b1;
        repeat (60) @(posedge i_clk_sys);
        chk(32'(o_low_power), 32'h1);
        axi_rd(ADDR_ISW);
        repeat (3) @(posedge i_clk_sys);
        chk(32'(o_low_power), 32'h0);
        // auto wake to normal mode after the wake-up time
        i_energy <= 1'b0;
        axi_wr(ADDR_PEC, 16'h00c1);
        wait_lp(1'b1);
        i_energy <= 1'b1;
        repeat (15) @(posedge i_clk_sys);
        chk(32'(o_low_power), 32'h1);
        wait_lp(1'b0);
        @(posedge i_clk_sys);
        chk({o_low_power, o_rxtx_en, o_irq}, 32'h3);
        axi_rd(ADDR_PEC);
        chk(32'(rd[5:0]), 32'h04);
        axi_rd(ADDR_ISW);
        chk(rd, 32'h00000004);
        axi_wr(ADDR_PEC, 16'h003c);
        // delayed assertion until clocks are ready
        pol <= 1'b1;
        axi_wr(ADDR_PEC, 16'h5180);
        pulse(4'h1);
        chk(32'(mon_wake), 32'h0);
        i_clocks_ready <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk(32'(mon_wake), 32'h1);
        // cause survives hw/sw reset, not power-up reset
        i_hwsw_rst <= 1'b1;
        @(posedge i_clk_sys);
        i_hwsw_rst <= 1'b0;
        axi_rd(ADDR_PEC);
        chk(32'(rd[5:2]), 32'h1);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        axi_rd(ADDR_PEC);
        chk(rd, 32'h0);
        print_verdict();
    end
endmodule

bind wepc_top wepc_chk u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
    .o_wake_event_output(o_wake_event_output), .o_irq(o_irq),
    .o_low_power(o_low_power), .o_rxtx_en(o_rxtx_en));
